// File: core/ahn_pkg.sv
// constants, tables and helpers shared by the capture filter chain
package ahn_pkg;
   localparam int ADDR_W = 7; // control port address width
   localparam int DATA_W = 9; // control port data width
   localparam int SMP_W = 24; // capture sample width
   localparam int COEF_W = 14; // notch coefficient width
   localparam int HALF_W = 7; // coefficient half held per register
   // register offsets
   localparam logic [6:0] ADR_SRATE = 7'h07;
   localparam logic [6:0] ADR_FILT = 7'h0E;
   localparam logic [6:0] ADR_VOL = 7'h0F;
   localparam logic [6:0] ADR_A0_HI = 7'h1B;
   localparam logic [6:0] ADR_A0_LO = 7'h1C;
   localparam logic [6:0] ADR_A1_HI = 7'h1D;
   localparam logic [6:0] ADR_A1_LO = 7'h1E;
   // field positions
   localparam int HPF_EN_BIT = 8;
   localparam int HPF_MODE_BIT = 7;
   localparam int HPF_CORNER_LSB = 4;
   localparam int SRATE_LSB = 1;
   localparam int NF_APPLY_BIT = 8;
   localparam int NF_EN_BIT = 7;
   // reset and mute values
   localparam logic [7:0] VOL_RST = 8'hFF;
   localparam logic [7:0] VOL_MUTE = 8'h00;
   // fixed point scalings
   localparam int HPF_K_FRAC = 16;
   localparam int A0_FRAC = 13;
   localparam int A1_FRAC = 12;
   localparam int VOL_FRAC = 15;
   localparam logic [7:0] VOL_STEPS_6DB = 8'h0C; // twelve half-dB steps
   // a halving is 6.02 dB, twelve half-dB steps only 6.00 dB: q15 trim per octave
   localparam logic [15:0] VOL_OCT_TRIM = 16'h004E;
   // pole offset 2*pi*fc/fs at the slowest rate of each family, q16
   localparam logic [15:0] HPF_K_AUDIO = 16'h00BE;
   localparam logic [15:0] HPF_K_TAB [8] = '{16'h107D, 16'h1482, 16'h1A57,
      16'h20C6, 16'h2904, 16'h347A, 16'h41BF, 16'h5208};
   // gain of 0..11 half-dB steps of attenuation, q15
   localparam logic [15:0] VOL_TAB [12] = '{16'h8000, 16'h78D7, 16'h7215,
      16'h6BB3, 16'h65AD, 16'h5FFD, 16'h5A9E, 16'h558C, 16'h50C3, 16'h4C3F,
      16'h47FB, 16'h43F4};
   localparam logic signed [47:0] SAT_HI = 48'sh0000_007F_FFFF;
   localparam logic signed [47:0] SAT_LO = 48'shFFFF_FF80_0000;

   // clamp a wide result into the sample range instead of wrapping
   function automatic logic signed [23:0] ahn_sat24(input logic signed [47:0] v);
      if (v > SAT_HI) begin
         return SAT_HI[23:0];
      end else if (v < SAT_LO) begin
         return SAT_LO[23:0];
      end
      return v[23:0];
   endfunction : ahn_sat24
endpackage : ahn_pkg

// File: core/ahn_hp_section.sv
// one first-order high-pass section with a programmable pole
`timescale 1ns/1ps
module ahn_hp_section (
   input wire logic i_clk, // sample processing clock
   input wire logic i_rstn, // async reset, active low
   input wire logic i_step, // advance state on this sample
   input wire logic [15:0] i_k, // pole offset, q16
   input wire logic signed [ahn_pkg::SMP_W-1:0] i_x, // section input
   output logic signed [ahn_pkg::SMP_W-1:0] o_y // section output
);
   import ahn_pkg::*;
   logic signed [SMP_W-1:0] x1_reg; // previous input
   logic signed [SMP_W-1:0] y1_reg; // previous output
   logic signed [47:0] acc; // wide sum before clamp

   // y = x - x1 + y1*(1-k), clamped
   always_comb begin
      acc = 48'(i_x) - 48'(x1_reg) + 48'(y1_reg)
         - ((48'(y1_reg) * 48'($signed({1'b0, i_k}))) >>> HPF_K_FRAC);
      o_y = ahn_sat24(acc);
   end

   // state moves only when a sample is consumed
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         x1_reg <= '0;
         y1_reg <= '0;
      end else if (i_step) begin
         x1_reg <= i_x;
         y1_reg <= o_y;
      end
   end
endmodule : ahn_hp_section

// File: core/ahn_capture_chain.sv
// capture path high-pass, notch and digital volume with its control registers
`timescale 1ns/1ps
module ahn_capture_chain (
   input wire logic i_clk, // 125 MHz core clock
   input wire logic i_rstn, // async reset, active low
   input wire logic i_reg_we, // control write strobe
   input wire logic [ahn_pkg::ADDR_W-1:0] i_reg_addr, // control address
   input wire logic [ahn_pkg::DATA_W-1:0] i_reg_wdata, // control write data
   output logic [ahn_pkg::DATA_W-1:0] o_reg_rdata, // read data, one cycle late
   input wire logic i_smp_valid, // decimator sample strobe
   input wire logic signed [ahn_pkg::SMP_W-1:0] i_smp_data, // decimator sample
   output logic o_smp_valid, // processed sample strobe
   output logic signed [ahn_pkg::SMP_W-1:0] o_smp_data // processed sample
);
   import ahn_pkg::*;

   // control state
   logic [2:0] sample_rate_sel; // rate code
   logic highpass_enable; // high-pass in path
   logic highpass_mode_sel; // 0 audio, 1 application
   logic [2:0] highpass_corner_sel; // application corner
   logic [7:0] capture_volume_code; // digital volume
   logic notch_enable; // notch in path
   logic [COEF_W-1:0] a0_stg_reg; // staged notch_coef_a0
   logic [COEF_W-1:0] a1_stg_reg; // staged notch_coef_a1
   logic [COEF_W-1:0] a0_stg_next;
   logic [COEF_W-1:0] a1_stg_next;
   logic signed [COEF_W-1:0] a0_work_reg; // notch_coef_a0 in use
   logic signed [COEF_W-1:0] a1_work_reg; // notch_coef_a1 in use
   logic coef_wr; // write to any coefficient register
   logic coef_apply; // that write also carries apply

   // decode coefficient writes, merging the new half into the staged word
   always_comb begin
      a0_stg_next = a0_stg_reg;
      a1_stg_next = a1_stg_reg;
      coef_wr = 1'b0;
      if (i_reg_we) begin
         unique case (i_reg_addr)
            ADR_A0_HI: begin
               a0_stg_next[COEF_W-1:HALF_W] = i_reg_wdata[HALF_W-1:0];
               coef_wr = 1'b1;
            end
            ADR_A0_LO: begin
               a0_stg_next[HALF_W-1:0] = i_reg_wdata[HALF_W-1:0];
               coef_wr = 1'b1;
            end
            ADR_A1_HI: begin
               a1_stg_next[COEF_W-1:HALF_W] = i_reg_wdata[HALF_W-1:0];
               coef_wr = 1'b1;
            end
            ADR_A1_LO: begin
               a1_stg_next[HALF_W-1:0] = i_reg_wdata[HALF_W-1:0];
               coef_wr = 1'b1;
            end
            default: coef_wr = 1'b0; // other addresses leave coefficients
         endcase
      end
      coef_apply = coef_wr && i_reg_wdata[NF_APPLY_BIT];
   end

   // staged coefficients follow every coefficient write
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         a0_stg_reg <= '0;
         a1_stg_reg <= '0;
      end else begin
         a0_stg_reg <= a0_stg_next;
         a1_stg_reg <= a1_stg_next;
      end
   end

   // working set moves only on apply, so both words change together
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         a0_work_reg <= '0;
         a1_work_reg <= '0;
      end else if (coef_apply) begin
         a0_work_reg <= a0_stg_next;
         a1_work_reg <= a1_stg_next;
      end
   end

   // plain configuration fields
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         sample_rate_sel <= '0;
         highpass_enable <= 1'b0;
         highpass_mode_sel <= 1'b0;
         highpass_corner_sel <= '0;
         capture_volume_code <= VOL_RST;
         notch_enable <= 1'b0;
      end else if (i_reg_we) begin
         if (i_reg_addr == ADR_SRATE) begin
            sample_rate_sel <= i_reg_wdata[SRATE_LSB +: 3];
         end
         if (i_reg_addr == ADR_FILT) begin
            highpass_enable <= i_reg_wdata[HPF_EN_BIT];
            highpass_mode_sel <= i_reg_wdata[HPF_MODE_BIT];
            highpass_corner_sel <= i_reg_wdata[HPF_CORNER_LSB +: 3];
         end
         if (i_reg_addr == ADR_VOL) begin
            capture_volume_code <= i_reg_wdata[7:0];
         end
         if (i_reg_addr == ADR_A0_HI) begin
            notch_enable <= i_reg_wdata[NF_EN_BIT];
         end
      end
   end

   // registered read back; apply bit and unused bits read zero
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_reg_rdata <= '0;
      end else begin
         unique case (i_reg_addr)
            ADR_SRATE: o_reg_rdata <= DATA_W'({sample_rate_sel, 1'b0});
            ADR_FILT: o_reg_rdata <= DATA_W'({highpass_enable, highpass_mode_sel,
               highpass_corner_sel, 4'h0});
            ADR_VOL: o_reg_rdata <= DATA_W'(capture_volume_code);
            ADR_A0_HI: o_reg_rdata <= DATA_W'({notch_enable, a0_stg_reg[COEF_W-1:HALF_W]});
            ADR_A0_LO: o_reg_rdata <= DATA_W'(a0_stg_reg[HALF_W-1:0]);
            ADR_A1_HI: o_reg_rdata <= DATA_W'(a1_stg_reg[COEF_W-1:HALF_W]);
            ADR_A1_LO: o_reg_rdata <= DATA_W'(a1_stg_reg[HALF_W-1:0]);
            default: o_reg_rdata <= '0; // unmapped reads as zero
         endcase
      end
   end

   // high-pass: pole offsets per family; fc/fs is fixed within a family
   logic [1:0] fam_shift; // 0: 8k, 1: 16k, 2: 32k family
   logic [15:0] k_corner; // application pole offset
   logic [15:0] k_audio; // audio pole offset
   logic [15:0] sec_k [2]; // per-section pole
   logic signed [SMP_W-1:0] sec_io [3]; // cascade taps
   always_comb begin
      unique case (sample_rate_sel[2:1])
         2'b01: fam_shift = 2'h1;
         2'b00: fam_shift = 2'h2;
         default: fam_shift = 2'h0; // 8k family and spare codes
      endcase
      k_corner = HPF_K_TAB[highpass_corner_sel] >> fam_shift;
      k_audio = HPF_K_AUDIO >> fam_shift;
      sec_k[0] = highpass_mode_sel ? k_corner : k_audio;
      sec_k[1] = k_corner;
   end
   assign sec_io[0] = i_smp_data;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_hp
         ahn_hp_section u_sec (
            .i_clk(i_clk),
            .i_rstn(i_rstn),
            .i_step(i_smp_valid && highpass_enable),
            .i_k(sec_k[gi]),
            .i_x(sec_io[gi]),
            .o_y(sec_io[gi+1])
         );
      end
   endgenerate

   // stage 1: high-pass result; second section only in application mode
   logic s1_valid;
   logic signed [SMP_W-1:0] s1_data;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s1_valid <= 1'b0;
         s1_data <= '0;
      end else begin
         s1_valid <= i_smp_valid;
         if (i_smp_valid) begin
            if (!highpass_enable) begin
               s1_data <= i_smp_data;
            end else if (highpass_mode_sel) begin
               s1_data <= sec_io[2];
            end else begin
               s1_data <= sec_io[1];
            end
         end
      end
   end

   // notch as half of input plus a second-order allpass
   // register words are -A0*2^13 and -A1*2^12, so signs are folded in
   logic signed [SMP_W-1:0] w1_reg; // allpass delay 1
   logic signed [SMP_W-1:0] w2_reg; // allpass delay 2
   logic signed [SMP_W-1:0] w_now; // allpass internal node
   logic signed [SMP_W-1:0] ap_out; // allpass output
   logic signed [SMP_W-1:0] nf_out; // notch output
   logic signed [47:0] t_a0w2;
   logic signed [47:0] t_a1w1;
   logic signed [47:0] t_a0w;
   always_comb begin
      t_a0w2 = (48'(a0_work_reg) * 48'(w2_reg)) >>> A0_FRAC;
      t_a1w1 = (48'(a1_work_reg) * 48'(w1_reg)) >>> A1_FRAC;
      w_now = ahn_sat24(48'(s1_data) + t_a1w1 + t_a0w2);
      t_a0w = (48'(a0_work_reg) * 48'(w_now)) >>> A0_FRAC;
      ap_out = ahn_sat24(48'(w2_reg) - t_a0w - t_a1w1);
      nf_out = ahn_sat24((48'(s1_data) + 48'(ap_out)) >>> 1);
   end

   // allpass state advances only while the notch is in the path
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         w1_reg <= '0;
         w2_reg <= '0;
      end else if (s1_valid && notch_enable) begin
         w1_reg <= w_now;
         w2_reg <= w1_reg;
      end
   end

   // stage 2: notch result
   logic s2_valid;
   logic signed [SMP_W-1:0] s2_data;
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         s2_valid <= 1'b0;
         s2_data <= '0;
      end else begin
         s2_valid <= s1_valid;
         if (s1_valid) begin
            s2_data <= notch_enable ? nf_out : s1_data;
         end
      end
   end

   // volume: halving per octave, fine steps from a twelve-entry table
   // plain halving drifts off the half-dB grid by 0.02 dB per octave, so a
   // linear trim per octave pulls it back; residual stays far below one step
   logic [7:0] att_steps; // half-dB steps below full scale
   logic [7:0] att_oct; // whole 6dB steps
   logic [7:0] att_fine; // remaining half-dB steps
   logic [15:0] vol_trim; // octave trim gain, q15
   logic signed [47:0] vol_fine; // sample after the fine step gain
   logic signed [47:0] vol_prod;
   always_comb begin
      att_steps = VOL_RST - capture_volume_code;
      att_oct = att_steps / VOL_STEPS_6DB;
      att_fine = att_steps % VOL_STEPS_6DB;
      vol_trim = VOL_TAB[0] + 16'(att_oct) * VOL_OCT_TRIM;
      vol_fine = (48'(s2_data) * 48'($signed({1'b0, VOL_TAB[att_fine[3:0]]}))) >>> VOL_FRAC;
      vol_prod = (vol_fine * 48'($signed({1'b0, vol_trim}))) >>> (8'(VOL_FRAC) + att_oct);
   end

   // stage 3: output, zero code mutes outright
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_smp_valid <= 1'b0;
         o_smp_data <= '0;
      end else begin
         o_smp_valid <= s2_valid;
         if (s2_valid) begin
            o_smp_data <= (capture_volume_code == VOL_MUTE) ? '0 : ahn_sat24(vol_prod);
         end
      end
   end

   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   sequence s_apply_write;
      i_reg_we && coef_wr && i_reg_wdata[NF_APPLY_BIT];
   endsequence
   property p_apply;
      s_apply_write ##1 1'b1 |-> a0_work_reg == a0_stg_reg && a1_work_reg == a1_stg_reg;
   endproperty
   a_apply: assert property (p_apply) else $error("apply did not load coefficients");
   property p_hold;
      !coef_apply |=> $stable(a0_work_reg) && $stable(a1_work_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("coefficients moved without apply");
   property p_latency;
      i_smp_valid |-> ##3 o_smp_valid;
   endproperty
   a_latency: assert property (p_latency) else $error("sample lost in chain");
   property p_hpf_bypass;
      i_smp_valid && !highpass_enable |=> s1_data == $past(i_smp_data);
   endproperty
   a_hpf_bypass: assert property (p_hpf_bypass) else $error("high-pass not bypassed");
   property p_nf_bypass;
      s1_valid && !notch_enable |=> s2_data == $past(s1_data);
   endproperty
   a_nf_bypass: assert property (p_nf_bypass) else $error("notch not bypassed");
   property p_mute;
      s2_valid && capture_volume_code == VOL_MUTE |=> o_smp_data == '0;
   endproperty
   a_mute: assert property (p_mute) else $error("zero volume did not mute");
   property p_unity;
      s2_valid && capture_volume_code == VOL_RST |=> o_smp_data == $past(s2_data);
   endproperty
   a_unity: assert property (p_unity) else $error("full volume not unity");
   property p_corner;
      i_reg_we && i_reg_addr == ADR_FILT |=>
         highpass_corner_sel == $past(i_reg_wdata[HPF_CORNER_LSB +: 3]);
   endproperty
   a_corner: assert property (p_corner) else $error("corner field misplaced");
endmodule : ahn_capture_chain

// File: sim/ahn_stream_partner.sv
// decimator source and serial-port sink model facing the capture chain
`timescale 1ns/1ps
module ahn_stream_partner (
   input wire logic i_clk, // core clock
   output logic o_valid, // sample strobe toward the chain
   output logic signed [23:0] o_data, // sample toward the chain
   input wire logic i_valid, // processed strobe from the chain
   input wire logic signed [23:0] i_data // processed sample from the chain
);
   // idle: strobe low, data parked at zero
   initial begin
      o_valid = 1'b0;
      o_data = 24'h00_0000;
   end

   // one 24-bit sample per strobe, then wait for its result
   task automatic xfer(input logic signed [23:0] x, output logic signed [23:0] y,
         output int lat);
      @(negedge i_clk);
      o_valid = 1'b1;
      o_data = x;
      lat = 0;
      y = 'x;
      do begin
         @(negedge i_clk);
         o_valid = 1'b0;
         o_data = ~x; // released data flips so a stale value never matches
         lat++;
      end while (i_valid !== 1'b1 && lat < 8);
      if (i_valid === 1'b1) begin
         y = i_data;
      end
   endtask : xfer
endmodule : ahn_stream_partner

// File: sim/adc_highpass_notch_volume_test.sv
// self-checking bench for the capture high-pass, notch and volume chain
`timescale 1ns/1ps
module adc_highpass_notch_volume_test;
   import ahn_pkg::*;
   logic i_clk; // core clock
   logic i_rstn; // async reset, active low
   logic i_reg_we; // control write strobe
   logic [ADDR_W-1:0] i_reg_addr; // control address
   logic [DATA_W-1:0] i_reg_wdata; // control write data
   logic [DATA_W-1:0] o_reg_rdata; // read data
   logic i_smp_valid; // sample strobe from partner
   logic signed [SMP_W-1:0] i_smp_data; // sample from partner
   logic o_smp_valid; // processed strobe
   logic signed [SMP_W-1:0] o_smp_data; // processed sample
   int err_count; // mismatches
   int n_compared; // comparisons made
   int cyc = 0; // cycles run, for the hang guard

   ahn_capture_chain i_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_reg_we(i_reg_we),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
      .i_smp_valid(i_smp_valid), .i_smp_data(i_smp_data), .o_smp_valid(o_smp_valid),
      .o_smp_data(o_smp_data));
   ahn_stream_partner i_src (.i_clk(i_clk), .o_valid(i_smp_valid), .o_data(i_smp_data),
      .i_valid(o_smp_valid), .i_data(o_smp_data));

   // 8 ns period
   always #4 i_clk = ~i_clk;

   // hang guard: well above the roughly 1300 cycles the scenarios need
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_count++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      if (err_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input bit ok, input string m);
      n_compared++;
      if (!ok) begin
         err_count++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask : chk

   // filter outputs are rounded, so compare within a tolerance
   function automatic bit near(input logic signed [23:0] a, b, input int tol);
      return ((a - b) <= tol) && ((b - a) <= tol);
   endfunction : near

   // reset held 8 cycles; also used between scenarios to clear filter state
   task automatic rst();
      @(negedge i_clk);
      i_rstn = 1'b0;
      repeat (8) @(negedge i_clk);
      i_rstn = 1'b1;
   endtask : rst

   task automatic wr(input logic [6:0] a, input logic [8:0] d);
      @(negedge i_clk);
      i_reg_we = 1'b1;
      i_reg_addr = a;
      i_reg_wdata = d;
      @(negedge i_clk);
      i_reg_we = 1'b0;
      i_reg_wdata = ~d;
   endtask : wr

   // read data lags the address by one edge
   task automatic rd(input logic [6:0] a, input logic [8:0] e, input string m);
      @(negedge i_clk);
      i_reg_addr = a;
      @(negedge i_clk);
      chk(o_reg_rdata === e, m);
   endtask : rd

   task automatic go(input logic signed [23:0] x, output logic signed [23:0] y);
      int lat;
      i_src.xfer(x, y, lat);
      chk(lat == 3, "latency");
   endtask : go

   task automatic feed(input logic signed [23:0] x, input int n,
         output logic signed [23:0] y);
      repeat (n) go(x, y);
   endtask : feed

   // impulse, one following sample, then a long flush of zeros
   task automatic imp(output logic signed [23:0] y0, y1);
      logic signed [23:0] t;
      go(24'h10_0000, y0);
      go(24'h00_0000, y1);
      feed(24'h00_0000, 30, t);
   endtask : imp

   task automatic t_regs();
      rst();
      rd(ADR_VOL, 9'h0FF, "volume reset");
      rd(ADR_A0_HI, 9'h000, "a0 high reset");
      rd(ADR_A1_LO, 9'h000, "a1 low reset");
      wr(ADR_FILT, 9'h1FF);
      rd(ADR_FILT, 9'h1F0, "filter fields");
      wr(ADR_FILT, 9'h0A0); // mode set, corner 010, enable clear
      rd(ADR_FILT, 9'h0A0, "filter field places");
      wr(ADR_SRATE, 9'h1FF);
      rd(ADR_SRATE, 9'h00E, "rate field");
      wr(ADR_A0_LO, 9'h155);
      rd(ADR_A0_LO, 9'h055, "a0 low half");
      wr(7'h10, 9'h1FF);
      rd(7'h10, 9'h000, "unmapped read");
   endtask : t_regs

   task automatic t_unity();
      logic signed [23:0] y;
      rst();
      go(24'hA5_5A5A, y);
      chk(y === 24'hA5_5A5A, "unity path");
      wr(ADR_FILT, 9'h0F0); // mode and corner set, enable clear
      wr(ADR_A0_HI, 9'h07F); // coefficient bits, notch off
      go(24'h12_3456, y);
      chk(y === 24'h12_3456, "filters bypassed");
   endtask : t_unity

   task automatic t_vol();
      logic signed [23:0] y;
      rst();
      wr(ADR_VOL, 9'h000);
      go(24'h40_0000, y);
      chk(y === 24'h00_0000, "mute");
      wr(ADR_VOL, 9'h1F3);
      rd(ADR_VOL, 9'h0F3, "volume read");
      go(24'h40_0000, y);
      chk(near(y, 24'h20_1354, 16'h1000), "minus 6 dB");
      wr(ADR_VOL, 9'h0FE);
      go(24'h40_0000, y);
      chk(near(y, 24'h3C_6BF8, 16'h1000), "half dB step");
   endtask : t_vol

   task automatic t_hpf();
      logic signed [23:0] y;
      rst();
      wr(ADR_SRATE, 9'h00A); // 8 kHz family
      wr(ADR_FILT, 9'h170); // audio mode, corner bits must be ignored
      feed(24'h10_0000, 40, y);
      chk(y > 24'sh0C_0000, "audio corner low");
      go(24'h80_0000, y); // full negative step drives the section past the range
      chk(y === 24'h80_0000, "negative clamp");
      go(24'h7F_FFFF, y); // full swing back would wrap without clamping
      chk(y === 24'h7F_FFFF, "positive clamp");
      rst();
      wr(ADR_SRATE, 9'h00A);
      wr(ADR_FILT, 9'h1F0); // application mode, top corner
      feed(24'h10_0000, 40, y);
      chk(near(y, 24'h00_0000, 16'h1000), "application decay");
      rst();
      wr(ADR_SRATE, 9'h006); // 16 kHz family: half the 8 kHz pole offset
      wr(ADR_FILT, 9'h1F0);
      feed(24'h10_0000, 40, y);
      chk(!near(y, 24'h00_0000, 16'h1000), "mid family decays slower");
      chk(near(y, 24'h00_0000, 16'h4000), "mid family decays faster");
      rst();
      wr(ADR_SRATE, 9'h002); // 32 kHz family: same code, lower pole offset
      wr(ADR_FILT, 9'h1F0);
      feed(24'h10_0000, 40, y);
      chk(!near(y, 24'h00_0000, 16'h4000), "rate scaling");
   endtask : t_hpf

   task automatic t_notch();
      logic signed [23:0] y0;
      logic signed [23:0] y1;
      rst();
      wr(ADR_A0_HI, 9'h080); // notch on, working set still zero
      imp(y0, y1);
      chk(near(y0, 24'h08_0000, 8) && near(y1, 24'h00_0000, 8), "zero set");
      wr(ADR_A1_HI, 9'h010); // staged only
      imp(y0, y1);
      chk(near(y1, 24'h00_0000, 8), "staged held back");
      wr(ADR_A1_LO, 9'h100); // apply: a1 register 0x0800
      rd(ADR_A1_LO, 9'h000, "apply bit reads 0");
      imp(y0, y1);
      chk(near(y1, 24'hFC_0000, 8), "a1 applied");
      wr(ADR_A0_HI, 9'h000); // notch out
      imp(y0, y1);
      chk(y0 === 24'h10_0000, "notch bypass");
   endtask : t_notch

   initial begin
      i_clk = 1'b0;
      i_rstn = 1'b0;
      i_reg_we = 1'b0;
      i_reg_addr = 7'h00;
      i_reg_wdata = 9'h000;
      err_count = 0;
      n_compared = 0;
      t_regs();
      t_unity();
      t_vol();
      t_hpf();
      t_notch();
      print_verdict();
   end
endmodule : adc_highpass_notch_volume_test
